//--- rtl/lshe_top.sv
`timescale 1ns/10ps
// Behaviour
// - Break flag set at break end, on the rising edge after over 11 dominant bits.
// - LIN interrupt status raised on break event when LIN interrupt enabled.
// - With hardware parity, identifier bits 31:30 are computed from bits 29:24.
// - With header watch enabled, full header sets header seen flag, interrupt.
// - Only identifier parity wrong sets parity error flag with header seen.
// - Mute keeps all characters out of receive stream, header characters included.
// - Control bit 2 enables auto baud resync; otherwise baud stays fixed.
// - Header not complete within 57 bit times sets error and timeout flags.
// - Timeout counter starts at break, stops on identifier, error, resync.
// - Mute ends after break, sync, or matching identifier per header select.
// - Auto resync times five sync falling edges, loads baud at fifth.
// - Measurement timer overflow before fifth edge sets header error.
// - Initial baud kept; reload enable restores it on next character.
// - Writing resync bit reloads initial baud and restarts header search.
// - Total sync span off over 14.84% sets header error, under 14.06% not.
// - Each sync edge interval off over 18.75% errors, under 15.62% not.
// - Header error on short delimiter, frame error, bad sync, timeouts.
// - Header select: 0 break, 1 break and sync, 2 break sync identifier.
// - Break detection enabled by bit 10 or by header watch, independent of receiver.
module lshe_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic lin_rx,
	output logic [31:0] baud_value,
	output logic [7:0] rx_data,
	output logic rx_push,
	output logic lin_irq
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic wait_r;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic ien;
		logic hseen;
		logic herr;
		logic iderr;
		logic tof;
		logic brkf;
		logic irqs;
		logic [31:0] baud;
		logic [31:0] init;
		lshe_pkg::lshe_hdr_st_t state;
		logic [15:0] delcnt;
		logic [12:0] meas;
		logic [12:0] last;
		logic [2:0] falls;
		logic tact;
		logic [15:0] tcnt;
		logic [5:0] tbits;
		logic [7:0] rxd;
		logic push;
	} lshe_top_st_t;
	lshe_top_st_t r, n;

	logic [15:0] bit_cycles;
	logic brk_pulse;
	logic [7:0] rx_byte;
	logic rx_ferr;
	logic rx_done;

	lshe_brk_det u_brk (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(r.ctrl[lshe_pkg::C_BRK] | (r.ctrl[lshe_pkg::C_SLV]
			& r.ctrl[lshe_pkg::C_HDR])),
		.rxd(r.s2),
		.bit_cycles(bit_cycles),
		.brk_pulse(brk_pulse)
	);

	lshe_byte_rx u_rx (
		.ref_clk(ref_clk),
		.rst(rst),
		.rxd(r.s2),
		.bit_cycles(bit_cycles),
		.rx_byte(rx_byte),
		.rx_ferr(rx_ferr),
		.rx_done(rx_done)
	);

	// The divider runs in the mode where one bit is divisor plus two cycles.
	assign bit_cycles = r.baud[15:0] + lshe_pkg::BAUD_EXTRA;

	always_comb begin
		logic fall, hdr_on, ar, wr, e_hdr, e_idp, e_herr, e_tout, e_brk;
		logic [31:0] wmask, clr_s, clr_i;
		logic [7:0] pid_eff;
		logic [19:0] ival;
		fall = 1'b0;
		hdr_on = 1'b0;
		ar = 1'b0;
		wr = 1'b0;
		e_hdr = 1'b0;
		e_idp = 1'b0;
		e_herr = 1'b0;
		e_tout = 1'b0;
		e_brk = 1'b0;
		wmask = 32'h0000_0000;
		clr_s = 32'h0000_0000;
		clr_i = 32'h0000_0000;
		ival = 20'h00000;
		pid_eff = 8'h00;
		n = r;
		n.s1 = lin_rx;
		n.s2 = r.s1;
		n.prev = r.s2;
		fall = r.prev & ~r.s2;
		hdr_on = r.ctrl[lshe_pkg::C_SLV] & r.ctrl[lshe_pkg::C_HDR];
		ar = r.ctrl[lshe_pkg::C_AR];
		pid_eff = r.ctrl[lshe_pkg::C_IDP]
			? lshe_pkg::lshe_pid_calc(r.ctrl[29:24])
			: r.ctrl[31:24];

		// One wait state: read data is latched while waitrequest is high, writes land while it is low.
		n.wait_r = ~((avs_read | avs_write) & r.wait_r);
		wr = avs_write & ~r.wait_r;
		wmask = lshe_pkg::lshe_merge(32'h0000_0000, 32'hffff_ffff,
			avs_byteenable);
		if (avs_read & r.wait_r) begin
			case (avs_address)
			lshe_pkg::OFS_CTRL: n.rdata = {pid_eff, r.ctrl[23:0]};
			lshe_pkg::OFS_STAT: n.rdata = {23'h000000, r.brkf, 3'h0,
				r.tof, 1'b0, r.iderr, r.herr, r.hseen};
			lshe_pkg::OFS_IEN: n.rdata = {23'h000000, r.ien, 8'h00};
			lshe_pkg::OFS_ISTS: n.rdata = {16'h0000, r.irqs, 15'h0000};
			lshe_pkg::OFS_BAUD: n.rdata = r.baud;
			default: n.rdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (avs_address)
			lshe_pkg::OFS_CTRL: begin
				n.ctrl = lshe_pkg::lshe_merge(r.ctrl, avs_writedata,
					avs_byteenable);
			end
			lshe_pkg::OFS_STAT: clr_s = avs_writedata & wmask;
			lshe_pkg::OFS_IEN: begin
				if (avs_byteenable[1]) begin
					n.ien = avs_writedata[lshe_pkg::IEN_LIN];
				end
			end
			lshe_pkg::OFS_ISTS: clr_i = avs_writedata & wmask;
			lshe_pkg::OFS_BAUD: begin
				// The shadow copy is what later reloads restore.
				n.baud = lshe_pkg::lshe_merge(r.baud, avs_writedata,
					avs_byteenable);
				n.init = n.baud;
			end
			default: ;
			endcase
		end

		// Receive stream: suppressed while mute is on.
		n.push = rx_done & ~r.ctrl[lshe_pkg::C_MUTE];
		if (rx_done) begin
			n.rxd = rx_byte;
		end
		if (rx_done && r.ctrl[lshe_pkg::C_RELOAD]) begin
			n.baud = r.init;
			n.ctrl[lshe_pkg::C_RELOAD] = 1'b0;
		end

		if (r.tact) begin
			if (r.tcnt >= bit_cycles - 16'h0001) begin
				n.tcnt = 16'h0000;
				n.tbits = r.tbits + 6'h01;
				if (r.tbits + 6'h01 >= lshe_pkg::TOUT_BITS) begin
					e_tout = 1'b1;
					e_herr = 1'b1;
				end
			end else begin
				n.tcnt = r.tcnt + 16'h0001;
			end
		end

		case (r.state)
		lshe_pkg::ST_IDLE: ;
		lshe_pkg::ST_DELIM: begin
			if (r.delcnt != 16'hffff) begin
				n.delcnt = r.delcnt + 16'h0001;
			end
			if (fall) begin
				if (r.delcnt < (bit_cycles >> 1)) begin
					e_herr = 1'b1;
				end else begin
					n.state = lshe_pkg::ST_SYNC;
					// Counting from one makes the span whole bit times.
					n.meas = 13'h0001;
					n.last = 13'h0000;
					n.falls = 3'h1;
					if (r.ctrl[23:22] == lshe_pkg::HSEL_BRK) begin
						n.ctrl[lshe_pkg::C_MUTE] = 1'b0;
					end
				end
			end
		end
		lshe_pkg::ST_SYNC: begin
			n.meas = r.meas + 13'h0001;
			if (ar && &r.meas && r.falls < lshe_pkg::SYNC_FALLS) begin
				e_herr = 1'b1;
			end
			if (ar && fall && r.falls < lshe_pkg::SYNC_FALLS) begin
				n.last = r.meas;
				n.falls = r.falls + 3'h1;
				ival = {7'h00, r.meas - r.last};
				if (lshe_pkg::lshe_dev_bad(ival, {3'h0, bit_cycles, 1'b0},
					lshe_pkg::CHK2_NUM, lshe_pkg::CHK2_SH)) begin
					e_herr = 1'b1;
				end
				if (r.falls + 3'h1 == lshe_pkg::SYNC_FALLS) begin
					if (lshe_pkg::lshe_dev_bad({7'h00, r.meas},
						{1'b0, bit_cycles, 3'h0}, lshe_pkg::CHK1_NUM,
						lshe_pkg::CHK1_SH)) begin
						e_herr = 1'b1;
					end else begin
						// Span covers eight bits; drop the two fixed cycles.
						n.baud[15:0] = {6'h00, r.meas[12:3]}
							- lshe_pkg::BAUD_EXTRA;
					end
				end
			end
			if (rx_done) begin
				if (rx_ferr || (!ar && rx_byte != lshe_pkg::SYNC_DATA)
					|| (ar && n.falls != lshe_pkg::SYNC_FALLS)) begin
					e_herr = 1'b1;
				end else begin
					n.state = lshe_pkg::ST_ID;
					if (r.ctrl[23:22] == lshe_pkg::HSEL_SYNC) begin
						n.ctrl[lshe_pkg::C_MUTE] = 1'b0;
					end
				end
			end
		end
		lshe_pkg::ST_ID: begin
			if (rx_done) begin
				if (rx_ferr) begin
					e_herr = 1'b1;
				end else begin
					e_hdr = 1'b1;
					e_idp = r.ctrl[lshe_pkg::C_IDP] && rx_byte
						!= lshe_pkg::lshe_pid_calc(rx_byte[5:0]);
					n.tact = 1'b0;
					n.state = lshe_pkg::ST_IDLE;
					if (r.ctrl[23:22] == lshe_pkg::HSEL_ID
						&& rx_byte == pid_eff) begin
						n.ctrl[lshe_pkg::C_MUTE] = 1'b0;
					end
				end
			end
		end
		lshe_pkg::ST_HOLD: ;
		default: n.state = lshe_pkg::ST_IDLE;
		endcase

		e_brk = brk_pulse & r.ctrl[lshe_pkg::C_BRK];
		if (brk_pulse && hdr_on && r.state != lshe_pkg::ST_HOLD) begin
			n.state = lshe_pkg::ST_DELIM;
			n.delcnt = 16'h0000;
			n.tact = 1'b1;
			n.tcnt = 16'h0000;
			n.tbits = 6'h00;
		end
		if (e_herr) begin
			// Detection stays parked until software asks for a new search.
			n.state = lshe_pkg::ST_HOLD;
			n.tact = 1'b0;
		end
		if (clr_s[lshe_pkg::S_RESYNC]) begin
			n.state = lshe_pkg::ST_IDLE;
			n.tact = 1'b0;
			n.baud = r.init;
		end
		if (!hdr_on) begin
			n.state = lshe_pkg::ST_IDLE;
			n.tact = 1'b0;
		end

		// Set wins over a clear that lands in the same cycle.
		n.hseen = (r.hseen & ~clr_s[lshe_pkg::S_HSEEN]) | e_hdr;
		n.herr = (r.herr & ~clr_s[lshe_pkg::S_HERR]) | e_herr;
		n.iderr = (r.iderr & ~clr_s[lshe_pkg::S_IDERR]) | e_idp;
		n.tof = (r.tof & ~clr_s[lshe_pkg::S_TOUT]) | e_tout;
		n.brkf = (r.brkf & ~clr_s[lshe_pkg::S_BRK]) | e_brk;
		n.irqs = (r.irqs & ~clr_i[lshe_pkg::ISTS_LIN])
			| (r.ien & (e_hdr | e_herr | e_idp | e_tout | e_brk));
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, wait_r: 1'b1,
				ctrl: lshe_pkg::CTRL_RST, baud: lshe_pkg::BAUD_RST,
				init: lshe_pkg::BAUD_RST, state: lshe_pkg::ST_IDLE,
				default: '0};
		end else begin
			r <= n;
		end
	end

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.wait_r;
	assign baud_value = r.baud;
	assign rx_data = r.rxd;
	assign rx_push = r.push;
	assign lin_irq = r.irqs;
endmodule // lshe_top

//--- rtl/lshe_pkg.sv
package lshe_pkg;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_IEN = 5'h08;
	localparam logic [4:0] OFS_ISTS = 5'h0c;
	localparam logic [4:0] OFS_BAUD = 5'h10;
	localparam int C_SLV = 0;
	localparam int C_HDR = 1;
	localparam int C_AR = 2;
	localparam int C_RELOAD = 3;
	localparam int C_MUTE = 4;
	localparam int C_IDP = 9;
	localparam int C_BRK = 10;
	localparam int S_HSEEN = 0;
	localparam int S_HERR = 1;
	localparam int S_IDERR = 2;
	localparam int S_RESYNC = 3;
	localparam int S_TOUT = 4;
	localparam int S_BRK = 8;
	localparam int IEN_LIN = 8;
	localparam int ISTS_LIN = 15;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BAUD_RST = 32'h3000_0000;
	localparam logic [1:0] HSEL_BRK = 2'h0;
	localparam logic [1:0] HSEL_SYNC = 2'h1;
	localparam logic [1:0] HSEL_ID = 2'h2;
	localparam logic [19:0] BRK_BITS = 20'h0000b;
	localparam logic [5:0] TOUT_BITS = 6'h39;
	localparam logic [2:0] SYNC_FALLS = 3'h5;
	localparam logic [7:0] SYNC_DATA = 8'h55;
	localparam logic [15:0] BAUD_EXTRA = 16'h0002;
	localparam logic [7:0] CHK1_NUM = 8'h13;
	localparam logic [4:0] CHK1_SH = 5'h07;
	localparam logic [7:0] CHK2_NUM = 8'h03;
	localparam logic [4:0] CHK2_SH = 5'h04;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DELIM = 5'h02,
		ST_SYNC = 5'h04,
		ST_ID = 5'h08,
		ST_HOLD = 5'h10
	} lshe_hdr_st_t;

	function automatic logic [7:0] lshe_pid_calc(input logic [5:0] id);
		lshe_pid_calc = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
			id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction

	function automatic logic lshe_dev_bad(input logic [19:0] act,
		input logic [19:0] nom, input logic [7:0] num, input logic [4:0] sh);
		logic [31:0] d;
		d = (act > nom) ? {12'h000, act - nom} : {12'h000, nom - act};
		lshe_dev_bad = (d << sh) > ({12'h000, nom} * {24'h000000, num});
	endfunction

	function automatic logic [31:0] lshe_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
		lshe_merge = old;
	endfunction
endpackage

//--- rtl/lshe_byte_rx.sv
`timescale 1ns/10ps
module lshe_byte_rx (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rxd,
	input wire logic [15:0] bit_cycles,
	output logic [7:0] rx_byte,
	output logic rx_ferr,
	output logic rx_done
);
	typedef struct packed {
		logic prev;
		logic busy;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic ferr;
		logic done;
	} lshe_brx_t;
	lshe_brx_t r, n;

	always_comb begin
		n = r;
		n.prev = rxd;
		n.done = 1'b0;
		if (!r.busy) begin
			if (r.prev && !rxd) begin
				n.busy = 1'b1;
				n.cnt = bit_cycles >> 1;
				n.bitn = 4'h0;
			end
		end else if (r.cnt != 16'h0000) begin
			n.cnt = r.cnt - 16'h0001;
		end else begin
			n.cnt = bit_cycles - 16'h0001;
			if (r.bitn == 4'h0) begin
				// A glitch shorter than half a bit is not a start bit.
				n.busy = !rxd;
				n.bitn = 4'h1;
			end else if (r.bitn <= 4'h8) begin
				n.sh = {rxd, r.sh[7:1]};
				n.bitn = r.bitn + 4'h1;
			end else begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.ferr = !rxd;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '{prev: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign rx_byte = r.sh;
	assign rx_ferr = r.ferr;
	assign rx_done = r.done;
endmodule // lshe_byte_rx

//--- rtl/lshe_brk_det.sv
`timescale 1ns/10ps
module lshe_brk_det (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic rxd,
	input wire logic [15:0] bit_cycles,
	output logic brk_pulse
);
	typedef struct packed {
		logic prev;
		logic [19:0] low_cnt;
		logic pulse;
	} lshe_brk_t;
	lshe_brk_t r, n;
	logic [19:0] limit;

	function automatic logic [19:0] brk_limit(input logic [15:0] b);
		logic [35:0] p;
		p = {20'h00000, b} * {16'h0000, lshe_pkg::BRK_BITS};
		brk_limit = (p[35:20] != 16'h0000) ? 20'hffffe : p[19:0];
	endfunction

	// Runs beside the character receiver and never looks at its state.
	always_comb begin
		limit = brk_limit(bit_cycles);
		n = r;
		n.prev = rxd;
		n.pulse = 1'b0;
		if (!enable || rxd) begin
			n.low_cnt = 20'h00000;
		end else if (r.low_cnt != 20'hfffff) begin
			n.low_cnt = r.low_cnt + 20'h00001;
		end
		if (enable && !r.prev && rxd && r.low_cnt > limit) begin
			n.pulse = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '{prev: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign brk_pulse = r.pulse;
endmodule // lshe_brk_det

//--- sim/lshe_top_assertions.sv
`timescale 1ns/10ps
module lshe_top_assertions (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic lin_rx,
	input wire logic [31:0] baud_value,
	input wire logic [7:0] rx_data,
	input wire logic rx_push,
	input wire logic lin_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire logic [5:0] rid = avs_readdata[29:24];
	wire logic ists_wr = avs_write && !avs_waitrequest &&
		avs_address == lshe_pkg::OFS_ISTS;
	sequence s_rd(logic [4:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	sequence s_wr(logic [4:0] a);
		avs_write && !avs_waitrequest && avs_address == a;
	endsequence
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no answer after one wait");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_pid_read: assert property (s_rd(lshe_pkg::OFS_CTRL) |->
		!avs_readdata[9] || avs_readdata[31:30] ==
		{~(rid[1] ^ rid[3] ^ rid[4] ^ rid[5]), rid[0] ^ rid[1] ^ rid[2] ^ rid[4]})
		else $error("parity bits wrong");
	a_resync_zero: assert property (s_rd(lshe_pkg::OFS_STAT) |->
		!avs_readdata[3]) else $error("resync bit reads one");
	a_baud_write: assert property (s_wr(lshe_pkg::OFS_BAUD) ##0
		avs_byteenable == 4'hf |=> baud_value == $past(avs_writedata))
		else $error("baud write lost");
	a_irq_clear: assert property (s_wr(lshe_pkg::OFS_ISTS) ##0
		(avs_writedata[15] && avs_byteenable[1]) |=> !lin_irq)
		else $error("interrupt not cleared");
	a_irq_hold: assert property (lin_irq && !ists_wr |=> lin_irq)
		else $error("interrupt dropped by itself");
	a_push_gap: assert property (rx_push |=> !rx_push [*8])
		else $error("push pulses too close");
endmodule // lshe_top_assertions

bind lshe_top lshe_top_assertions u_lshe_top_assertions (
	.ref_clk(ref_clk),
	.rst(rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.lin_rx(lin_rx),
	.baud_value(baud_value),
	.rx_data(rx_data),
	.rx_push(rx_push),
	.lin_irq(lin_irq)
);

//--- sim/lshe_lin_master.sv
`timescale 1ns/10ps
module lshe_lin_master (
	output logic lin_tx,
	input wire logic ref_clk
);
	int bit_clk = 16;
	// The bus idles recessive through its pull-up, so released means 1.
	initial lin_tx = 1'b1;
	task automatic hold(input logic v, input int n);
		lin_tx <= v;
		repeat (n * bit_clk) @(posedge ref_clk);
	endtask
	task automatic send_break(input int n);
		hold(1'b0, n);
		hold(1'b1, 1);
	endtask
	task automatic send_byte(input logic [7:0] b);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(b[i], 1);
		end
		hold(1'b1, 1);
	endtask
endmodule // lshe_lin_master

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic lin_rx, rx_push, lin_irq;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [7:0] rx_data;
	logic [31:0] avs_writedata, avs_readdata, baud_value, rdv;
	int err_total = 0;
	int tests_run = 0;
	int push_cnt = 0;

	lshe_top u_lshe_top (
		.ref_clk(ref_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.lin_rx(lin_rx),
		.baud_value(baud_value),
		.rx_data(rx_data),
		.rx_push(rx_push),
		.lin_irq(lin_irq)
	);
	lshe_lin_master u_lshe_lin_master (
		.lin_tx(lin_rx),
		.ref_clk(ref_clk)
	);

	initial begin
		ref_clk = 1'b0;
		forever begin
			#12.5 ref_clk = ~ref_clk;
		end
	end
	always @(posedge ref_clk) begin
		if (rx_push === 1'b1) begin
			push_cnt++;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Ends one cycle after release so two calls never drive at one edge.
	// A slave that never answers is caught by a_wait_one and the watchdog.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~w;
		avs_write <= w;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic ctl(input logic [31:0] d);
		bus(1'b1, lshe_pkg::OFS_CTRL, d);
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, lshe_pkg::OFS_STAT, 32'h0);
		chk(rdv & m, e);
	endtask
	// Resync in the same write restarts the header search after errors.
	task automatic clr;
		bus(1'b1, lshe_pkg::OFS_STAT, 32'h0000_011f);
		bus(1'b1, lshe_pkg::OFS_ISTS, 32'h0000_8000);
	endtask
	task automatic hdr(input logic [7:0] id);
		u_lshe_lin_master.send_break(13);
		u_lshe_lin_master.send_byte(8'h55);
		u_lshe_lin_master.send_byte(id);
	endtask
	function automatic logic [7:0] pid_of(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction

	task automatic t_regs;
		bus(1'b0, 5'h14, 32'hffff_ffff);
		chk(rdv, 32'h0);
		chk(baud_value, lshe_pkg::BAUD_RST);
		for (int i = 0; i < 64; i += 9) begin
			ctl({2'b00, 6'(i), 24'h000200});
			bus(1'b0, lshe_pkg::OFS_CTRL, 32'h0);
			chk(rdv, {pid_of(6'(i)), 24'h000200});
		end
		ctl(32'hd200_0000);
		bus(1'b0, lshe_pkg::OFS_CTRL, 32'h0);
		chk(rdv, 32'hd200_0000);
		bus(1'b1, lshe_pkg::OFS_BAUD, 32'h3000_000e);
		avs_byteenable <= 4'h1;
		bus(1'b1, lshe_pkg::OFS_BAUD, 32'h5555_550e);
		chk(baud_value, 32'h3000_000e);
		avs_byteenable <= 4'hf;
		$display("register test done");
	endtask
	task automatic t_break;
		bus(1'b1, lshe_pkg::OFS_IEN, 32'h0000_0100);
		ctl(32'h0000_0400);
		u_lshe_lin_master.send_break(10);
		stat(32'h100, 32'h0);
		u_lshe_lin_master.send_break(12);
		stat(32'h100, 32'h100);
		chk(32'(lin_irq), 32'h1);
		bus(1'b1, lshe_pkg::OFS_STAT, 32'h0);
		bus(1'b1, lshe_pkg::OFS_ISTS, 32'h0);
		stat(32'h100, 32'h100);
		chk(32'(lin_irq), 32'h1);
		clr;
		stat(32'h100, 32'h0);
		$display("break test done");
	endtask
	task automatic t_header;
		ctl(32'h1200_0203);
		hdr(8'h92);
		stat(32'h7, 32'h1);
		chk(baud_value, 32'h3000_000e);
		chk(32'(lin_irq), 32'h1);
		clr;
		hdr(8'h12);
		stat(32'h7, 32'h5);
		clr;
		u_lshe_lin_master.send_break(13);
		u_lshe_lin_master.send_byte(8'h54);
		u_lshe_lin_master.send_byte(8'h92);
		stat(32'h3, 32'h2);
		$display("header test done");
	endtask
	task automatic t_tout;
		clr;
		ctl(32'h0000_0003);
		u_lshe_lin_master.send_break(13);
		repeat (50 * 16) @(posedge ref_clk);
		stat(32'h12, 32'h0);
		repeat (8 * 16) @(posedge ref_clk);
		stat(32'h12, 32'h12);
		clr;
		hdr(8'h92);
		repeat (60 * 16) @(posedge ref_clk);
		stat(32'h13, 32'h1);
		$display("timeout test done");
	endtask
	task automatic t_mute;
		int n0;
		for (int h = 0; h < 3; h++) begin
			clr;
			ctl({8'h92, 2'(h), 22'h000013});
			n0 = push_cnt;
			hdr(8'h92);
			u_lshe_lin_master.send_byte(8'ha5);
			chk(32'(push_cnt - n0), 32'(3 - h));
			chk({24'h0, rx_data}, 32'ha5);
			stat(32'h7, 32'h1);
			bus(1'b0, lshe_pkg::OFS_CTRL, 32'h0);
			chk(rdv & 32'h10, 32'h0);
		end
		clr;
		ctl(32'h9280_0013);
		n0 = push_cnt;
		hdr(8'h11);
		u_lshe_lin_master.send_byte(8'ha5);
		chk(32'(push_cnt - n0), 32'h0);
		bus(1'b0, lshe_pkg::OFS_CTRL, 32'h0);
		chk(rdv & 32'h10, 32'h10);
		$display("mute test done");
	endtask
	task automatic t_auto;
		clr;
		ctl(32'h0000_0007);
		// Six percent slow: the sync byte still frames at the old rate.
		u_lshe_lin_master.bit_clk = 17;
		hdr(8'h92);
		chk({16'h0, baud_value[15:0]}, 32'hf);
		stat(32'h2, 32'h0);
		clr;
		chk(baud_value, 32'h3000_000e);
		hdr(8'h92);
		ctl(32'h0000_000f);
		u_lshe_lin_master.send_byte(8'h00);
		chk(baud_value, 32'h3000_000e);
		bus(1'b0, lshe_pkg::OFS_CTRL, 32'h0);
		chk(rdv & 32'h8, 32'h0);
		clr;
		u_lshe_lin_master.bit_clk = 21;
		hdr(8'h92);
		stat(32'h2, 32'h2);
		u_lshe_lin_master.bit_clk = 16;
		$display("resync test done");
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_regs;
		t_break;
		t_header;
		t_tout;
		t_mute;
		t_auto;
		wrap_up;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		wrap_up;
	end
endmodule // tb
